// [rtl/tba_annunciator.sv]
`timescale 1ns/1ps
`default_nettype none
module tba_annunciator #(
  parameter int MS_CYCLES   = tba_pkg::TICK_CYCLES,  // Clock cycles per ms tick
  parameter int WIF_MS      = tba_pkg::WIF_MS,       // Filter alarm length
  parameter int DUMP_OFF_MS = tba_pkg::DUMP_OFF_MS   // Dump lamp off delay
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  input  wire logic [tba_pkg::NUM_IN-1:0]  ind_pin,
  input  wire logic                        ign_pin,
  input  wire logic [7:0]                  air_front_psi,
  input  wire logic [7:0]                  air_rear_psi,
  input  wire logic                        eng_stop_cmd,
  input  wire logic                        eng_check_cmd,
  input  wire logic [7:0]                  oil_press,
  input  wire logic [7:0]                  cool_temp,
  output logic [tba_pkg::LAMP_W-1:0]       lamp,
  output logic                             buzzer,
  output logic                             irq
);
  localparam int N      = tba_pkg::NUM_IN;
  localparam int EV_W_L = tba_pkg::EV_W;  // Interrupt event count

  logic [15:0]      ms_cnt;          // Prescaler
  logic             ms_tick;         // One cycle per ms
  logic [N:0]       sync1;           // First stage, read only by sync2
  logic [N:0]       sync2;           // Synchronised ignition and inputs
  logic             ign;             // Ignition on
  logic [N-1:0]     active;          // Inputs after polarity
  logic [N-1:0]     gated;           // Inputs after ignition gating
  logic [1:0]       boot_cnt;        // Start-up sequencing
  logic             boot_go;         // Synchroniser settled, one cycle
  logic             lt_busy;         // Lamp test timer running
  logic             lamp_test;       // All lamps forced on
  logic             wif_busy;        // Filter alarm timer running
  logic             low_air;         // Low air alarm latched
  logic             eng_warn;        // Engine warning condition
  logic [7:0]       cool_lim;        // Coolant limit
  logic [7:0]       oil_lim;         // Oil pressure limit
  logic             fire_act;        // Fire alarm input active
  logic             tv_act;          // Antenna plug alarm active
  logic [15:0]      fire_cnt;        // Fire half-period counter
  logic             fire_phase;      // Fire pulse level
  logic [15:0]      tv_cnt;          // Antenna half-period counter
  logic             tv_phase;        // Antenna pulse level
  logic             turn_q;          // Previous turn lamp state
  logic             click_busy;      // Click timer running
  tba_pkg::tba_dump_t dump_st;       // Dump sequencer state
  tba_pkg::tba_dump_t next_dump_st;  // Next dump state
  logic             dump_load;       // Restart dump timer
  logic             dump_busy;       // Dump timer running
  logic             dump_lamp;       // Dump lamp and buzzer request
  tba_pkg::tba_src_t src;            // Winning buzzer source
  logic             next_buzzer;     // Buzzer level for winner
  logic [EV_W_L-1:0] lvl;            // Event levels
  logic [EV_W_L-1:0] lvl_q;          // Delayed event levels
  logic [EV_W_L-1:0] irq_stat;       // Sticky events
  logic [EV_W_L-1:0] irq_en;         // Event enables
  logic             wr_pend;         // Write data phase pending
  logic [7:0]       wr_addr;         // Write offset
  logic             addr_ok;         // Valid address phase this cycle
  logic [N-1:0]     normal;          // Discrete lamps before lamp test

  // Half-period end test shared by both pulse generators
  function automatic logic tba_half_end(input logic [15:0] cnt, input int half);
    tba_half_end = (cnt == 16'(half - 1));
  endfunction

  // Millisecond prescaler; every ms timer and pulse generator runs from this tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt <= 16'h0000;
    end else if (ms_tick) begin
      ms_cnt <= 16'h0000;
    end else begin
      ms_cnt <= ms_cnt + 16'h0001;
    end
  end
  assign ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));

  // Two-stage synchroniser for every pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {ign_pin, ind_pin};
      sync2 <= sync1;
    end
  end
  sync_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn, 2) |-> sync2 == $past({ign_pin, ind_pin}, 2))
    else $error("input synchroniser is not two stages");

  // Polarity, then ignition gating
  assign ign    = sync2[N];
  assign active = sync2[N-1:0] ~^ tba_pkg::HIGH_ACTIVE_MASK;
  assign gated  = active & (tba_pkg::IGN_FREE_MASK | {N{ign}});

  // Start-up: wait for the synchroniser before sampling the strap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt <= 2'h0;
    end else if (boot_cnt != 2'h3) begin
      boot_cnt <= boot_cnt + 2'h1;
    end
  end
  assign boot_go = (boot_cnt == 2'h2);

  // Lamp test timer
  tba_ms_timer #(.W(tba_pkg::TMR_W)) u_lamp_test (
    .clk      (hclk),
    .rst_n    (hresetn),
    .tick     (ms_tick),
    .load     (boot_go),
    .load_val (tba_pkg::TMR_W'(tba_pkg::LAMP_TEST_MS)),
    .busy     (lt_busy)
  );
  assign lamp_test = (boot_cnt != 2'h3) || lt_busy;

  // Filter strap is caught once, after release, never while reset holds
  tba_ms_timer #(.W(tba_pkg::TMR_W)) u_wif (
    .clk      (hclk),
    .rst_n    (hresetn),
    .tick     (ms_tick),
    .load     (boot_go && active[tba_pkg::IN_WIF]),
    .load_val (tba_pkg::TMR_W'(WIF_MS)),
    .busy     (wif_busy)
  );

  // Low air latch with hysteresis; set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_air <= 1'b0;
    end else if (air_front_psi <= tba_pkg::LOW_AIR_SET_PSI ||
                 air_rear_psi <= tba_pkg::LOW_AIR_SET_PSI) begin
      low_air <= 1'b1;
    end else if (air_front_psi >= tba_pkg::LOW_AIR_CLR_PSI &&
                 air_rear_psi >= tba_pkg::LOW_AIR_CLR_PSI) begin
      low_air <= 1'b0;
    end
  end
  air_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (air_front_psi <= 8'h3E || air_rear_psi <= 8'h3E) |=> low_air)
    else $error("low air not raised at threshold");
  air_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    low_air && !(air_front_psi >= 8'h46 && air_rear_psi >= 8'h46) |=> low_air)
    else $error("low air released before both systems recovered");

  // Engine warning: stop or check command with oil below its limit or coolant above its limit
  assign eng_warn = (eng_stop_cmd || eng_check_cmd) &&
                    (oil_press < oil_lim || cool_temp > cool_lim);

  // Pulse generators restart high each time their source comes on
  assign fire_act = gated[tba_pkg::IN_FIRE];
  assign tv_act   = gated[tba_pkg::IN_TVANT];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fire_cnt   <= 16'h0000;
      fire_phase <= 1'b1;
    end else if (!fire_act) begin
      fire_cnt   <= 16'h0000;
      fire_phase <= 1'b1;
    end else if (ms_tick) begin
      if (tba_half_end(fire_cnt, tba_pkg::FIRE_HALF_MS)) begin
        fire_cnt   <= 16'h0000;
        fire_phase <= ~fire_phase;
      end else begin
        fire_cnt <= fire_cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tv_cnt   <= 16'h0000;
      tv_phase <= 1'b1;
    end else if (!tv_act) begin
      tv_cnt   <= 16'h0000;
      tv_phase <= 1'b1;
    end else if (ms_tick) begin
      if (tba_half_end(tv_cnt, tba_pkg::TV_HALF_MS)) begin
        tv_cnt   <= 16'h0000;
        tv_phase <= ~tv_phase;
      end else begin
        tv_cnt <= tv_cnt + 16'h0001;
      end
    end
  end
  fire_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fire_act && $past(fire_act) && $changed(fire_phase)
      |-> $past(fire_cnt) == 16'(tba_pkg::FIRE_HALF_MS - 1) && $past(ms_tick))
    else $error("fire pulse half period is not 250 ms");
  tv_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tv_act && $past(tv_act) && $changed(tv_phase)
      |-> $past(tv_cnt) == 16'(tba_pkg::TV_HALF_MS - 1) && $past(ms_tick))
    else $error("antenna pulse half period is not 500 ms");

  // Turn click when either turn lamp comes on with both previously off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      turn_q <= 1'b0;
    end else begin
      turn_q <= gated[tba_pkg::IN_LTURN] || gated[tba_pkg::IN_RTURN];
    end
  end
  tba_ms_timer #(.W(tba_pkg::TMR_W)) u_click (
    .clk      (hclk),
    .rst_n    (hresetn),
    .tick     (ms_tick),
    .load     ((gated[tba_pkg::IN_LTURN] || gated[tba_pkg::IN_RTURN]) && !turn_q),
    .load_val (tba_pkg::TMR_W'(tba_pkg::CLICK_MS)),
    .busy     (click_busy)
  );
  click_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(gated[tba_pkg::IN_LTURN] || gated[tba_pkg::IN_RTURN]) |=> click_busy)
    else $error("turn indicator on without click");

  // Suspension dump: on-delay while dumped, off-delay after recovery
  always_comb begin
    next_dump_st = dump_st;
    dump_load    = 1'b0;
    unique case (dump_st)
      tba_pkg::DUMP_IDLE: begin
        if (gated[tba_pkg::IN_DUMP]) begin
          next_dump_st = tba_pkg::DUMP_ONWAIT;
          dump_load    = 1'b1;
        end
      end
      tba_pkg::DUMP_ONWAIT: begin
        if (!gated[tba_pkg::IN_DUMP]) begin
          next_dump_st = tba_pkg::DUMP_IDLE;
        end else if (!dump_busy) begin
          next_dump_st = tba_pkg::DUMP_ON;
        end
      end
      tba_pkg::DUMP_ON: begin
        if (!gated[tba_pkg::IN_DUMP]) begin
          next_dump_st = tba_pkg::DUMP_OFFWAIT;
          dump_load    = 1'b1;
        end
      end
      tba_pkg::DUMP_OFFWAIT: begin
        if (gated[tba_pkg::IN_DUMP]) begin
          next_dump_st = tba_pkg::DUMP_ON;
        end else if (!dump_busy) begin
          next_dump_st = tba_pkg::DUMP_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dump_st <= tba_pkg::DUMP_IDLE;
    end else begin
      dump_st <= next_dump_st;
    end
  end
  tba_ms_timer #(.W(tba_pkg::TMR_W)) u_dump (
    .clk      (hclk),
    .rst_n    (hresetn),
    .tick     (ms_tick),
    .load     (dump_load),
    .load_val (dump_st == tba_pkg::DUMP_IDLE ? tba_pkg::TMR_W'(tba_pkg::DUMP_ON_MS)
                                              : tba_pkg::TMR_W'(DUMP_OFF_MS)),
    .busy     (dump_busy)
  );
  assign dump_lamp = dump_st[1];
  dump_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dump_st == tba_pkg::DUMP_ONWAIT && dump_busy |=> !dump_lamp)
    else $error("dump lamp on before the on-delay ran out");

  // Priority: only the highest active source reaches the buzzer
  always_comb begin
    if (fire_act)                              src = tba_pkg::SRC_FIRE;
    else if (low_air)                          src = tba_pkg::SRC_AIR;
    else if (eng_warn)                         src = tba_pkg::SRC_ENG;
    else if (tv_act)                           src = tba_pkg::SRC_TV;
    else if (wif_busy)                         src = tba_pkg::SRC_WIF;
    else if (dump_lamp)                        src = tba_pkg::SRC_DUMP;
    else if (click_busy)                       src = tba_pkg::SRC_TURN;
    else                                       src = tba_pkg::SRC_NONE;
  end
  always_comb begin
    unique case (src)
      tba_pkg::SRC_FIRE: next_buzzer = fire_phase;
      tba_pkg::SRC_TV:   next_buzzer = tv_phase;
      tba_pkg::SRC_NONE: next_buzzer = 1'b0;
      default:           next_buzzer = 1'b1;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buzzer <= 1'b0;
    end else begin
      buzzer <= next_buzzer;
    end
  end
  prio_fire_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fire_act |=> buzzer == $past(fire_phase))
    else $error("fire alarm did not own the buzzer");
  eng_cont_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (eng_warn && !fire_act && !low_air)[*2] |-> buzzer)
    else $error("engine warning buzzer not continuous");
  wif_buz_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wif_busy && src == tba_pkg::SRC_WIF |=> buzzer)
    else $error("filter alarm not sounding");
  turn_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    click_busy && tv_act && !fire_act && !low_air && !eng_warn
      |=> buzzer == $past(tv_phase))
    else $error("lower source overrode antenna pattern");

  // Lamp drive; lamp test forces everything on
  always_comb begin
    normal                   = gated;
    normal[tba_pkg::IN_DUMP] = dump_lamp;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp <= '1;
    end else if (lamp_test) begin
      lamp <= '1;
    end else begin
      lamp <= {eng_check_cmd, eng_stop_cmd, low_air, normal};
    end
  end
  lamp_test_a: assert property (@(posedge hclk) disable iff (!hresetn)
    lamp_test |=> lamp == '1)
    else $error("lamp test did not light every lamp");
  ign_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ign && !lamp_test && !dump_lamp
      |=> (lamp[N-1:0] & ~tba_pkg::IGN_FREE_MASK) == '0)
    else $error("ignition-dependent lamp lit with ignition off");

  // Interrupt events on rising levels; set wins over clear
  assign lvl = {~lamp_test, dump_lamp, eng_warn, fire_act, low_air};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q    <= '0;
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      lvl_q    <= lvl;
      irq_stat <= (irq_stat & ~((wr_pend && wr_addr == tba_pkg::OFF_IRQ_CLR) ?
                  hwdata[EV_W_L-1:0] : '0)) | (lvl & ~lvl_q);
      irq      <= |(irq_stat & irq_en);
    end
  end

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && htrans[1] && hready && hsize == tba_pkg::HSIZE_WORD;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Writable registers, updated in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cool_lim <= tba_pkg::COOL_LIMIT_RST;
      oil_lim  <= tba_pkg::OIL_LIMIT_RST;
      irq_en   <= tba_pkg::IRQ_EN_RST;
    end else if (wr_pend && wr_addr == tba_pkg::OFF_LIMITS) begin
      cool_lim <= hwdata[tba_pkg::LIM_COOL_LSB +: 8];
      oil_lim  <= hwdata[tba_pkg::LIM_OIL_LSB +: 8];
    end else if (wr_pend && wr_addr == tba_pkg::OFF_IRQ_EN) begin
      irq_en <= hwdata[EV_W_L-1:0];
    end
  end
  limits_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed({cool_lim, oil_lim}) |-> $past(wr_pend && wr_addr == tba_pkg::OFF_LIMITS))
    else $error("limits changed without a register write");

  // Read data registered in the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= 32'h0000_0000;
      unique case (haddr[7:0])
        tba_pkg::OFF_LIMITS:   hrdata[15:0]   <= {cool_lim, oil_lim};
        tba_pkg::OFF_STATUS:   hrdata[23:0]   <= {low_air, src, buzzer, lamp};
        tba_pkg::OFF_IRQ_STAT: hrdata[EV_W_L-1:0] <= irq_stat;
        tba_pkg::OFF_IRQ_EN:   hrdata[EV_W_L-1:0] <= irq_en;
        default:               hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// [rtl/tba_pkg.sv]
package tba_pkg;
  // Clock and base tick
  localparam int CLK_HZ       = 25_000_000;       // System clock rate
  localparam int TICK_TIME_MS = 1;                // Prescaled tick period
  localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int TMR_W        = 16;               // Width of ms timers

  // Durations in their own units, then in ms ticks
  localparam int WIF_TIME_S        = 30;
  localparam int WIF_MS            = WIF_TIME_S * 1000 / TICK_TIME_MS;
  localparam int LAMP_TEST_TIME_S  = 2;
  localparam int LAMP_TEST_MS      = LAMP_TEST_TIME_S * 1000 / TICK_TIME_MS;
  localparam int DUMP_ON_TIME_S    = 2;
  localparam int DUMP_ON_MS        = DUMP_ON_TIME_S * 1000 / TICK_TIME_MS;
  localparam int DUMP_OFF_TIME_MIN = 1;
  localparam int DUMP_OFF_MS       = DUMP_OFF_TIME_MIN * 60000 / TICK_TIME_MS;
  localparam int CLICK_TIME_MS     = 10;
  localparam int CLICK_MS          = CLICK_TIME_MS / TICK_TIME_MS;

  // Pulse rates in tenths of a hertz, half periods in ms ticks
  localparam int FIRE_RATE_DHZ = 20;
  localparam int FIRE_HALF_MS  = 10000 / (2 * FIRE_RATE_DHZ) / TICK_TIME_MS;
  localparam int TV_RATE_DHZ   = 10;
  localparam int TV_HALF_MS    = 10000 / (2 * TV_RATE_DHZ) / TICK_TIME_MS;

  // Air pressure hysteresis in PSI
  localparam logic [7:0] LOW_AIR_SET_PSI = 8'h3E;
  localparam logic [7:0] LOW_AIR_CLR_PSI = 8'h46;

  // Engine critical limits after reset
  localparam logic [7:0] COOL_LIMIT_RST = 8'hDC;
  localparam logic [7:0] OIL_LIMIT_RST  = 8'h0A;

  // Register byte offsets
  localparam logic [7:0] OFF_LIMITS   = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h10;

  // Field positions
  localparam int LIM_OIL_LSB  = 0;
  localparam int LIM_COOL_LSB = 8;
  localparam int ST_BUZ_BIT   = 19;
  localparam int ST_SRC_LSB   = 20;
  localparam int ST_AIR_BIT   = 23;

  // Discrete indicator inputs
  localparam int NUM_IN     = 16;
  localparam int IN_LTURN   = 0;
  localparam int IN_RTURN   = 1;
  localparam int IN_HIBEAM  = 2;
  localparam int IN_FIRE    = 3;
  localparam int IN_DUMP    = 4;
  localparam int IN_LEVEL   = 5;
  localparam int IN_HEADLT  = 6;
  localparam int IN_WIF     = 7;
  localparam int IN_TVANT   = 8;
  localparam int IN_PARK    = 9;
  localparam int IN_LOWCOOL = 10;
  localparam int IN_HYDOIL  = 11;
  localparam int IN_ENGBRK  = 12;
  localparam int IN_DAYLT   = 13;
  localparam int IN_LOWFUEL = 14;
  localparam int IN_TRACT   = 15;
  localparam logic [15:0] HIGH_ACTIVE_MASK = 16'h007F; // Active at +12V
  localparam logic [15:0] IGN_FREE_MASK    = 16'h006F; // Work without ignition

  // Lamp outputs beyond the discrete ones
  localparam int LAMP_W       = 19;
  localparam int LAMP_LOW_AIR = 16;
  localparam int LAMP_STOP    = 17;
  localparam int LAMP_CHECK   = 18;

  // Interrupt events
  localparam int EV_W       = 5;
  localparam logic [4:0] IRQ_EN_RST = 5'h00;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Buzzer sources after SRC_NONE, highest priority first
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_FIRE = 3'h1,
    SRC_AIR  = 3'h2,
    SRC_ENG  = 3'h3,
    SRC_TV   = 3'h4,
    SRC_WIF  = 3'h5,
    SRC_DUMP = 3'h6,
    SRC_TURN = 3'h7
  } tba_src_t;

  // Suspension dump sequencer
  typedef enum logic [1:0] {
    DUMP_IDLE    = 2'h0,
    DUMP_ONWAIT  = 2'h1,
    DUMP_ON      = 2'h3,
    DUMP_OFFWAIT = 2'h2
  } tba_dump_t;
endpackage

// [rtl/tba_ms_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// Down counter in ms ticks; busy while nonzero
module tba_ms_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy
);
  logic [W-1:0] count;  // Remaining ticks

  // Load wins over counting so a retrigger restarts the interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (tick && count != '0) begin
      count <= count - W'(1);
    end
  end

  assign busy = (count != '0);
endmodule
`default_nettype wire

// [verif/tba_vehicle_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Vehicle switch harness: turns wanted conditions into pin levels
module tba_vehicle_model (
  input  wire logic [15:0] act,     // One bit per active condition
  output logic      [15:0] ind_pin  // Pin levels as wired
);
  // Listed inputs pull to +12V, the rest pull to ground when active
  assign ind_pin = act ^ ~tba_pkg::HIGH_ACTIVE_MASK;
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, ign, stp, ckc, hrdy, hrsp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [15:0] act, pins;
  logic [7:0]  af, ar, oil, cool;
  logic [18:0] lamp;
  logic        buzzer, irq;
  int          bad_count, tests_run;
  // Small counts keep the run short
  tba_annunciator #(.MS_CYCLES(4), .WIF_MS(50), .DUMP_OFF_MS(40)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hrsp), .hrdata(hrdata), .ind_pin(pins), .ign_pin(ign), .air_front_psi(af),
    .air_rear_psi(ar), .eng_stop_cmd(stp), .eng_check_cmd(ckc), .oil_press(oil),
    .cool_temp(cool), .lamp(lamp), .buzzer(buzzer), .irq(irq));
  tba_vehicle_model u_veh (.act(act), .ind_pin(pins));
  // Clock, 40 ns period
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Single word transfer, waits on ready in both phases
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hrdy !== 1'b1);
    d = hrdata;
    chk(hrsp, 1'b0);
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Filter strap grounded across release, then the lamp test
  task automatic scen_boot;
    xfer(1'b0, 32'h00, 32'h0);
    chk(d, 32'h0000DC0A);
    cyc(40);
    chk(buzzer, 1'b1);
    xfer(1'b0, 32'h04, 32'h0);
    chk(d[22:20], 3'h5);
    cyc(300);
    chk(buzzer, 1'b0);
    act <= 16'h0000;
    cyc(7400);
    chk(lamp, 19'h7FFFF);
    cyc(400);
    chk(lamp, 19'h00000);
  endtask
  // Low air hysteresis, at each mark and one PSI inside the band
  task automatic scen_air;
    xfer(1'b1, 32'h10, 32'h1);
    af <= 8'h3F;
    cyc(10);
    chk(lamp[16], 1'b0);
    af <= 8'h3E;
    cyc(10);
    chk({lamp[16], buzzer, irq}, 3'h7);
    af <= 8'h4B;
    ar <= 8'h45;
    cyc(10);
    chk(lamp[16], 1'b1);
    ar <= 8'h46;
    cyc(10);
    chk({lamp[16], buzzer}, 2'h0);
    xfer(1'b1, 32'h0C, 32'h1);
    cyc(3);
    chk(irq, 1'b0);
  endtask
  // Fire beats low air and pulses at 2 Hz
  task automatic scen_fire;
    af  <= 8'h32;
    act <= 16'h0008;
    cyc(500);
    chk(buzzer, 1'b1);
    cyc(1000);
    chk(buzzer, 1'b0);
    xfer(1'b0, 32'h04, 32'h0);
    chk(d[22:20], 3'h1);
    act <= 16'h0000;
    af  <= 8'h64;
  endtask
  // Stop lamp against a raised oil limit, then check lamp with hot coolant
  task automatic scen_eng;
    xfer(1'b1, 32'h00, 32'h0000DC14);
    oil <= 8'h0F;
    stp <= 1'b1;
    repeat (3) begin
      cyc(500);
      chk(buzzer, 1'b1);
    end
    oil <= 8'h19;
    cyc(10);
    chk(buzzer, 1'b0);
    xfer(1'b0, 32'h00, 32'h0);
    chk(d, 32'h0000DC14);
    xfer(1'b0, 32'h40, 32'h0);
    chk(d, 32'h0);
    stp  <= 1'b0;
    ckc  <= 1'b1;
    cool <= 8'hDD;
    cyc(10);
    chk({lamp[18:17], buzzer}, 3'h5);
    cool <= 8'hDC;
    cyc(10);
    chk(buzzer, 1'b0);
    ckc <= 1'b0;
  endtask
  // Turn click, then ignition off and on with a ground-active lamp
  task automatic scen_turn;
    act <= 16'h0001;
    cyc(10);
    chk({lamp[0], buzzer}, 2'h3);
    cyc(60);
    chk(buzzer, 1'b0);
    ign <= 1'b0;
    act <= 16'h8005;
    cyc(10);
    chk(lamp[15:0], 16'h0005);
    ign <= 1'b1;
    cyc(10);
    chk(lamp[15:0], 16'h8005);
  endtask
  // Antenna plug pulses at 1 Hz and a turn click cannot break in
  task automatic scen_tv;
    act <= 16'h0100;
    cyc(1000);
    chk({lamp[8], buzzer}, 2'h3);
    cyc(2000);
    chk(buzzer, 1'b0);
    act <= 16'h0101;
    cyc(20);
    chk(buzzer, 1'b0);
    act <= 16'h0000;
  endtask
  // Suspension dump: on-delay while dumped, off-delay after recovery
  task automatic scen_dump;
    act <= 16'h0010;
    cyc(7000);
    chk({lamp[4], buzzer}, 2'h0);
    cyc(1100);
    chk({lamp[4], buzzer}, 2'h3);
    act <= 16'h0000;
    cyc(100);
    chk(lamp[4], 1'b1);
    cyc(100);
    chk({lamp[4], buzzer}, 2'h0);
  endtask
  // Watchdog
  initial begin
    cyc(40000);
    bad_count++;
    give_verdict();
  end
  // Main sequence: filter strap grounded across release
  initial begin
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = '0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = '0;
    ign       = 1'b1;
    stp       = 1'b0;
    ckc       = 1'b0;
    act       = 16'h0080;
    af        = 8'h64;
    ar        = 8'h64;
    oil       = 8'h32;
    cool      = 8'h64;
    bad_count = 0;
    tests_run = 0;
    cyc(12);
    hresetn <= 1'b1;
    scen_boot();
    scen_air();
    scen_fire();
    scen_eng();
    scen_turn();
    scen_tv();
    scen_dump();
    give_verdict();
  end
endmodule
`default_nettype wire
